// [rtl/fsl_pkg.sv]
// fsl_pkg: constants and types for the frequent start limiter
// assumes a 100 MHz sys_clk and APB with 32-bit data
package fsl_pkg;
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned CYCLE_US       = 1_000;
  localparam int unsigned CYCLE_CLKS     = (CLK_HZ / 1_000_000) * CYCLE_US;
  localparam int unsigned MS_PER_CYCLE   = CYCLE_US / 1_000;
  localparam int unsigned MS_PER_S       = 1_000;
  localparam int unsigned MS_PER_HOUR    = 3_600_000;
  localparam int unsigned CYCLES_PER_HOUR = MS_PER_HOUR / MS_PER_CYCLE;

  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STARTS  = 12'h004;
  localparam logic [11:0] ADDR_STALL   = 12'h008;
  localparam logic [11:0] ADDR_MINGAP  = 12'h00C;
  localparam logic [11:0] ADDR_STATUS  = 12'h010;
  localparam logic [11:0] ADDR_COUNTER = 12'h014;
  localparam logic [11:0] ADDR_TIMES   = 12'h018;

  localparam logic [6:0]  STARTS_COLD_RST = 7'h03;
  localparam logic [6:0]  STARTS_HOT_RST  = 7'h02;
  localparam logic [6:0]  HOURS_RST       = 7'h01;
  localparam logic [9:0]  HOT_LIMIT_RST   = 10'h2BC;
  localparam logic [12:0] STALL_COLD_RST  = 13'h00C8;
  localparam logic [12:0] STALL_HOT_RST   = 13'h0096;
  localparam logic [15:0] MINGAP_RST      = 16'h0000;

  localparam int unsigned CNT_W = 48;

  typedef enum logic [2:0] {
    FSL_MODE_ON      = 3'h1,
    FSL_MODE_BLOCKED = 3'h2,
    FSL_MODE_TEST    = 3'h3,
    FSL_MODE_TESTBLK = 3'h4,
    FSL_MODE_OFF     = 3'h5
  } fsl_mode_e;

  typedef enum logic [1:0] {
    FSL_COND_NORMAL  = 2'h0,
    FSL_COND_START   = 2'h1,
    FSL_COND_TRIP    = 2'h2,
    FSL_COND_BLOCKED = 2'h3
  } fsl_cond_e;
endpackage

// [rtl/fsl_cfg_if.sv]
// fsl_cfg_if: settings passed from register file to the counter core
// assumes both ends run on sys_clk
interface fsl_cfg_if;
  logic [6:0]  starts_cold;
  logic [6:0]  starts_hot;
  logic [6:0]  hours;
  logic [12:0] stall_cold;
  logic [12:0] stall_hot;
  logic [15:0] min_gap_s;
  logic        hot;
  logic        active;
  logic [47:0] counter;
  logic [7:0]  used;
  logic [7:0]  avail;
  logic        gap_block;
  modport regs (output starts_cold, starts_hot, hours, stall_cold,
                stall_hot, min_gap_s, hot, active,
                input counter, used, avail, gap_block);
  modport core (input starts_cold, starts_hot, hours, stall_cold,
                stall_hot, min_gap_s, hot, active,
                output counter, used, avail, gap_block);
endinterface

// [rtl/fsl_core.sv]
// fsl_core: start stress counter raised on each start in any mode but Off and decayed once per program cycle
// assumes motor_start_indication is a one-cycle pulse on sys_clk
module fsl_core (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic motor_start_indication,
  fsl_cfg_if.core   cfg
);
  // units: counter in 0.1 s times cycles-per-hour times hours, so decrement is integral
  logic [47:0] cnt_reg;
  logic [31:0] tick_reg;
  logic        tick;
  logic [31:0] gap_reg;
  logic [12:0] stall;
  logic [6:0]  starts;
  logic [47:0] inc;
  logic [47:0] dec;
  logic [47:0] per_start;
  logic [47:0] divq;

  assign tick   = (tick_reg == fsl_pkg::CYCLE_CLKS - 1);
  assign stall  = cfg.hot ? cfg.stall_hot : cfg.stall_cold;
  assign starts = cfg.hot ? cfg.starts_hot : cfg.starts_cold;
  // one start adds a whole stall time regardless of start length
  assign per_start = 48'(stall) * 48'(fsl_pkg::CYCLES_PER_HOUR)
                     * 48'(cfg.hours);
  assign inc = per_start;
  // stall time / hours, spread over the hour's cycles
  assign dec = 48'(stall);
  assign divq = (per_start == 48'h0) ? 48'h0 : cnt_reg / per_start;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn || tick)
      tick_reg <= 32'h0;
    else
      tick_reg <= tick_reg + 32'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      cnt_reg <= 48'h0;
    else if (cfg.active && motor_start_indication)
      cnt_reg <= cnt_reg + inc - (tick && cnt_reg >= dec ? dec : 48'h0);
    else if (tick)
      cnt_reg <= (cnt_reg > dec) ? cnt_reg - dec : 48'h0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      gap_reg <= 32'h0;
    else if (motor_start_indication)
      gap_reg <= 32'(cfg.min_gap_s) * 32'(fsl_pkg::MS_PER_S);
    else if (tick && gap_reg != 32'h0)
      gap_reg <= gap_reg - 32'(fsl_pkg::MS_PER_CYCLE);
  end

  assign cfg.counter   = cnt_reg;
  assign cfg.gap_block = (gap_reg != 32'h0);
  assign cfg.used      = (divq > 48'(starts)) ? 8'(starts) : 8'(divq);
  assign cfg.avail     = 8'(starts) - cfg.used;

  // a cycle without a counted start removes one stall time, floor zero
  cnt_decay_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    tick && !(cfg.active && motor_start_indication) && cnt_reg > dec
    |=> cnt_reg == $past(cnt_reg) - $past(dec))
    else $error("counter not reduced by one stall time");
  cnt_floor_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    tick && !(cfg.active && motor_start_indication) && cnt_reg <= dec
    |=> cnt_reg == 48'h0)
    else $error("counter did not stop at zero");
  off_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !cfg.active && !tick |=> cnt_reg == $past(cnt_reg))
    else $error("start counted while switched off");
  gap_load_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    motor_start_indication && cfg.min_gap_s != 16'h0000
    |=> cfg.gap_block)
    else $error("minimum gap not started");
endmodule // fsl_core

// [rtl/fsl_top.sv]
// fsl_top: frequent start limiter with APB register file
// assumes APB master on sys_clk and thermal status from the overload block
//
// The APB register port and the register addresses are this design's own decisions.
module fsl_top (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        motor_start_indication,
  input  wire logic [9:0]  thermal_used,
  output logic             alarm,
  output logic             restart_inhibit,
  output logic [1:0]       condition
);
  fsl_cfg_if cfg ();

  logic [2:0]  logical_node_setting;
  logic [2:0]  logical_node_effective;
  logic [6:0]  starts_cold_reg;
  logic [6:0]  starts_hot_reg;
  logic [6:0]  hours_reg;
  logic [9:0]  hot_limit_reg;
  logic [12:0] stall_cold_reg;
  logic [12:0] stall_hot_reg;
  logic [15:0] min_gap_reg;
  logic        hot_reg;
  logic        wr;
  logic        rd;
  logic        blocked_mode;
  logic        alarm_next;
  logic        inhibit_next;
  logic [1:0]  cond_next;
  logic [31:0] rd_next;
  logic        map_hit;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == fsl_pkg::ADDR_CTRL)   || (a == fsl_pkg::ADDR_STARTS) ||
             (a == fsl_pkg::ADDR_STALL)  || (a == fsl_pkg::ADDR_MINGAP) ||
             (a == fsl_pkg::ADDR_STATUS) || (a == fsl_pkg::ADDR_COUNTER) ||
             (a == fsl_pkg::ADDR_TIMES);
  endfunction

  function automatic logic [6:0] min1(input logic [6:0] v);
    min1 = (v == 7'h00) ? 7'h01 : v;
  endfunction

  assign map_hit = mapped(paddr);
  assign wr = psel && penable && pwrite && map_hit;
  assign rd = psel && !penable && !pwrite;

  // mode lives outside setting groups so a group change cannot touch it
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      logical_node_setting <= fsl_pkg::FSL_MODE_ON;
    else if (wr && paddr == fsl_pkg::ADDR_CTRL &&
             pwdata[2:0] >= fsl_pkg::FSL_MODE_ON &&
             pwdata[2:0] <= fsl_pkg::FSL_MODE_OFF)
      logical_node_setting <= pwdata[2:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      starts_cold_reg <= fsl_pkg::STARTS_COLD_RST;
      starts_hot_reg  <= fsl_pkg::STARTS_HOT_RST;
      hours_reg       <= fsl_pkg::HOURS_RST;
      hot_limit_reg   <= fsl_pkg::HOT_LIMIT_RST;
    end
    else if (wr && paddr == fsl_pkg::ADDR_STARTS)
    begin
      starts_cold_reg <= min1(pwdata[6:0]);
      starts_hot_reg  <= min1(pwdata[14:8]);
      hours_reg       <= min1(pwdata[22:16]);
    end
    else if (wr && paddr == fsl_pkg::ADDR_CTRL)
      hot_limit_reg <= pwdata[25:16];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      stall_cold_reg <= fsl_pkg::STALL_COLD_RST;
      stall_hot_reg  <= fsl_pkg::STALL_HOT_RST;
    end
    else if (wr && paddr == fsl_pkg::ADDR_STALL)
    begin
      stall_cold_reg <= pwdata[12:0];
      stall_hot_reg  <= pwdata[28:16];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      min_gap_reg <= fsl_pkg::MINGAP_RST;
    else if (wr && paddr == fsl_pkg::ADDR_MINGAP)
      min_gap_reg <= pwdata[15:0];
  end

  // relies on the thermal block feeding thermal_used in 0.1 % steps
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      hot_reg <= 1'b0;
    else
      hot_reg <= (thermal_used > hot_limit_reg);
  end

  assign cfg.starts_cold = starts_cold_reg;
  assign cfg.starts_hot  = starts_hot_reg;
  assign cfg.hours       = hours_reg;
  assign cfg.stall_cold  = stall_cold_reg;
  assign cfg.stall_hot   = stall_hot_reg;
  assign cfg.min_gap_s   = min_gap_reg;
  assign cfg.hot         = hot_reg;
  assign cfg.active      = (logical_node_setting != fsl_pkg::FSL_MODE_OFF);

  // no override path exists, so the effective mode is the set one
  assign logical_node_effective = logical_node_setting;

  fsl_core u_core (
    .sys_clk                (sys_clk),
    .rstn                   (rstn),
    .motor_start_indication (motor_start_indication),
    .cfg                    (cfg)
  );

  assign blocked_mode = (logical_node_setting == fsl_pkg::FSL_MODE_BLOCKED) ||
                        (logical_node_setting == fsl_pkg::FSL_MODE_TESTBLK);

  always_comb
  begin
    alarm_next   = (cfg.avail == 8'h01);
    inhibit_next = (cfg.avail == 8'h00) || cfg.gap_block
                   || (hot_reg && cfg.avail <= 8'h01);
    cond_next    = inhibit_next ? fsl_pkg::FSL_COND_TRIP :
                   (alarm_next ? fsl_pkg::FSL_COND_START :
                                 fsl_pkg::FSL_COND_NORMAL);
    if (logical_node_setting == fsl_pkg::FSL_MODE_OFF)
    begin
      alarm_next   = 1'b0;
      inhibit_next = 1'b0;
      cond_next    = fsl_pkg::FSL_COND_NORMAL;
    end
    else if (blocked_mode)
    begin
      alarm_next   = 1'b0;
      inhibit_next = 1'b0;
      cond_next    = fsl_pkg::FSL_COND_BLOCKED;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      alarm           <= 1'b0;
      restart_inhibit <= 1'b0;
      condition       <= fsl_pkg::FSL_COND_NORMAL;
    end
    else
    begin
      alarm           <= alarm_next;
      restart_inhibit <= inhibit_next;
      condition       <= cond_next;
    end
  end

  always_comb
  begin
    case (paddr)
      fsl_pkg::ADDR_CTRL:
        rd_next = {6'h0, hot_limit_reg, 5'h0, logical_node_effective,
                   5'h0, logical_node_setting};
      fsl_pkg::ADDR_STARTS:
        rd_next = {9'h0, hours_reg, 1'b0, starts_hot_reg, 1'b0,
                   starts_cold_reg};
      fsl_pkg::ADDR_STALL:
        rd_next = {3'h0, stall_hot_reg, 3'h0, stall_cold_reg};
      fsl_pkg::ADDR_MINGAP:
        rd_next = {16'h0, min_gap_reg};
      fsl_pkg::ADDR_STATUS:
        rd_next = {cfg.avail, cfg.used, 11'h0, hot_reg,
               restart_inhibit, alarm, condition};
      fsl_pkg::ADDR_COUNTER:
        rd_next = cfg.counter[31:0];
      fsl_pkg::ADDR_TIMES:
        rd_next = {16'h0, cfg.counter[47:32]};
      default:
        rd_next = 32'h0;
    endcase
  end

  // no wait state: data captured in setup, ready in the first access cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      if (rd)
        prdata <= rd_next;
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !map_hit;
    end
  end

  mode_default_a: assert property (@(posedge sys_clk)
    $rose(rstn) |-> logical_node_setting == fsl_pkg::FSL_MODE_ON)
    else $error("mode not On after reset");
  off_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    logical_node_setting == fsl_pkg::FSL_MODE_OFF
    |=> !alarm && !restart_inhibit)
    else $error("outputs active in Off");
  blk_cond_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    blocked_mode |=> condition == fsl_pkg::FSL_COND_BLOCKED)
    else $error("blocked not reported");
  alarm_one_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    cfg.avail == 8'h01 && logical_node_setting == fsl_pkg::FSL_MODE_ON
    |=> alarm)
    else $error("alarm missing at one start left");
  inhibit_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    cfg.avail == 8'h00 && logical_node_setting == fsl_pkg::FSL_MODE_ON
    |=> restart_inhibit)
    else $error("inhibit missing at no start left");
  gap_block_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    cfg.gap_block && cfg.active && !blocked_mode
    |=> restart_inhibit)
    else $error("gap not blocking");
  hot_inhibit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    hot_reg && cfg.avail <= 8'h01 && cfg.active && !blocked_mode
    |=> restart_inhibit)
    else $error("hot inhibit missing");
  cnt_grow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    motor_start_indication && cfg.active |=> cfg.counter > $past(cfg.counter))
    else $error("start did not add stress");

  // bus handshake: each setup cycle is answered once, in the access cycle
  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence apb_answer_s;
    pready ##1 !pready;
  endsequence

  apb_answer_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    apb_setup_s |=> apb_answer_s)
    else $error("bus answer not one cycle long");
  slverr_map_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    apb_setup_s |=> pslverr == !$past(map_hit))
    else $error("error response does not match the address map");
  rd_capture_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    apb_setup_s ##0 !pwrite |=> prdata == $past(rd_next))
    else $error("read data not taken in the setup cycle");

  // the condition code must agree with the pins it summarises
  cond_trip_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    restart_inhibit |-> condition == fsl_pkg::FSL_COND_TRIP)
    else $error("inhibit without Trip condition");
  cond_start_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    alarm && !restart_inhibit |-> condition == fsl_pkg::FSL_COND_START)
    else $error("alarm without Start condition");
  mode_legal_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    logical_node_setting >= fsl_pkg::FSL_MODE_ON &&
    logical_node_setting <= fsl_pkg::FSL_MODE_OFF)
    else $error("mode outside its five codes");
  mode_keep_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !(wr && paddr == fsl_pkg::ADDR_CTRL) |=> $stable(logical_node_setting))
    else $error("mode changed without a control write");
  hot_sense_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    rstn && thermal_used > hot_limit_reg |=> hot_reg)
    else $error("hot status missed above the limit");
endmodule // fsl_top

// [sim/fsl_motor_model.sv]
// fsl_motor_model: far side of the limiter, start pulses and thermal level
// assumes tasks are called right after a rising edge of sys_clk
module fsl_motor_model (
  input  wire logic       sys_clk,
  output logic            motor_start_indication,
  output logic [9:0]      thermal_used
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    motor_start_indication = 1'b0;
    thermal_used           = 10'h000;
  end

  // one-cycle pulse per attempt, then a quiet cycle
  task automatic start_pulse();
    motor_start_indication <= 1'b1;
    @(posedge sys_clk);
    motor_start_indication <= 1'b0;
    @(posedge sys_clk);
  endtask

  // level held until changed; stands in for the overload function
  task automatic set_thermal(input logic [9:0] v);
    thermal_used <= v;
    @(posedge sys_clk);
  endtask
endmodule // fsl_motor_model

// [sim/testbench.sv]
// testbench: self-checking bench for fsl_top over APB
// assumes fsl_motor_model drives the start pulse and thermal level
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        pready, pslverr, alarm, restart_inhibit, mstart;
  logic [31:0] prdata, rd;
  logic [1:0]  condition;
  logic [9:0]  thermal_used;
  logic        err;
  int          miscompares = 0;
  int          comparisons = 0;
  longint      cnt, per;
  int          v, eff, stall, hrs;

  always #5 sys_clk = ~sys_clk;

  fsl_top DUT (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .motor_start_indication(mstart), .thermal_used(thermal_used),
    .alarm(alarm), .restart_inhibit(restart_inhibit),
    .condition(condition));
  fsl_motor_model MOT (.sys_clk(sys_clk), .motor_start_indication(mstart),
    .thermal_used(thermal_used));

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  // setup, access until pready, release, then one idle edge;
  // no answer time is assumed, a hung slave is left to the watchdog
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rchk(input string w, input logic [11:0] a,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(w, e, rd);
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    cnt = 0;
  endtask

  task automatic start();
    MOT.start_pulse();
    repeat (3) @(posedge sys_clk);
  endtask

  // status word and output pins checked together
  task automatic st(input int c, a, i, u, n);
    rchk("status", fsl_pkg::ADDR_STATUS,
         {n[7:0], u[7:0], 12'h000, i[0], a[0], c[1:0]});
    chk("alarm", a, alarm);
    chk("inhibit", i, restart_inhibit);
    chk("condition", c, condition);
  endtask

  task automatic cchk();
    rchk("cnt_lo", fsl_pkg::ADDR_COUNTER, cnt[31:0]);
    rchk("cnt_hi", fsl_pkg::ADDR_TIMES, {16'h0000, cnt[47:32]});
  endtask

  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #200000;
    miscompares++;
    complete_run();
  end

  initial
  begin
    v = $urandom(17039);
    do_reset();
    rchk("ctrl", fsl_pkg::ADDR_CTRL, 32'h02BC_0101);
    rchk("starts", fsl_pkg::ADDR_STARTS, 32'h0001_0203);
    rchk("stall", fsl_pkg::ADDR_STALL, 32'h0096_00C8);
    rchk("mingap", fsl_pkg::ADDR_MINGAP, 32'h0000_0000);
    rchk("unmapped", 12'h01C, 32'h0000_0000);
    chk("slverr", 32'h1, err);
    st(0, 0, 0, 0, 3);
    // cold starts: alarm on the last but one, inhibit on the last
    per = longint'(200) * fsl_pkg::CYCLES_PER_HOUR;
    for (int i = 1; i <= 3; i++)
    begin
      start();
      cnt += per;
      v = 3 - i;
      st(v == 0 ? 2 : (v == 1), v == 1, v == 0, i, v);
      cchk();
    end
    // mode codes, illegal codes leave the setting alone
    do_reset();
    eff = 1;
    for (int m = 0; m <= 6; m++)
    begin
      apb(1'b1, fsl_pkg::ADDR_CTRL, {16'h02BC, 13'h0000, 3'(m)});
      if (m >= 1 && m <= 5)
        eff = m;
      rchk("mode", fsl_pkg::ADDR_CTRL,
           {16'h02BC, 5'h00, 3'(eff), 5'h00, 3'(eff)});
    end
    repeat (3) start();
    st(0, 0, 0, 0, 3);
    cchk();
    do_reset();
    apb(1'b1, fsl_pkg::ADDR_CTRL, 32'h02BC_0002);
    repeat (3) start();
    chk("blk_cond", 3, condition);
    chk("blk_inh", 0, restart_inhibit);
    // hot motor: one hot start leaves one, inhibit held while hot
    do_reset();
    MOT.set_thermal(10'd701);
    start();
    // one hot start of two: one used, one left, hot, inhibit, alarm, Trip
    rchk("hot", fsl_pkg::ADDR_STATUS, 32'h0101_001E);
    chk("hot_inh", 1, restart_inhibit);
    MOT.set_thermal(10'd700);
    repeat (3) @(posedge sys_clk);
    apb(1'b0, fsl_pkg::ADDR_STATUS, 32'h0);
    chk("cold", 0, rd[4]);
    chk("cold_inh", 0, restart_inhibit);
    // zero start count raised to one, minimum gap inhibits restart after one start
    do_reset();
    apb(1'b1, fsl_pkg::ADDR_STARTS, 32'h0000_0000);
    rchk("starts0", fsl_pkg::ADDR_STARTS, 32'h0001_0101);
    apb(1'b1, fsl_pkg::ADDR_STARTS, 32'h0001_6464);
    apb(1'b1, fsl_pkg::ADDR_MINGAP, 32'h0000_0001);
    start();
    chk("gap_inh", 1, restart_inhibit);
    // random stall and time frame, stress added per start
    do_reset();
    repeat (3)
    begin
      stall = 1 + $urandom % 6000;
      hrs   = 1 + $urandom % 4;
      apb(1'b1, fsl_pkg::ADDR_STALL, {16'h0096, 3'h0, 13'(stall)});
      apb(1'b1, fsl_pkg::ADDR_STARTS, {9'h000, 7'(hrs), 16'h6464});
      start();
      cnt += longint'(stall) * fsl_pkg::CYCLES_PER_HOUR * hrs;
      cchk();
    end
    complete_run();
  end
endmodule // testbench
